// file: dio_pkg.sv
package dio_pkg;
   localparam int NUM_IN = 16;
   localparam int NUM_OUT = 4;
   localparam int SUM_W = 32;
   localparam int ADDR_W = 8;
   // Register word addresses
   localparam logic [7:0] A_IN_CFG_EN = 8'h00;
   localparam logic [7:0] A_IN_INVERT = 8'h01;
   localparam logic [7:0] A_IN_FORCE_EN = 8'h02;
   localparam logic [7:0] A_IN_FORCE_VAL = 8'h03;
   localparam logic [7:0] A_IN_RAW = 8'h04;
   localparam logic [7:0] A_IN_ROUTE_EN = 8'h05;
   localparam logic [7:0] A_IN_SUMMARY = 8'h06;
   localparam logic [7:0] A_OUT_CTRL = 8'h07;
   localparam logic [7:0] A_OUT_POL = 8'h08;
   localparam logic [7:0] A_OUT_MAN_EN = 8'h09;
   localparam logic [7:0] A_OUT_MAN_VAL = 8'h0a;
   localparam logic [7:0] A_OUT_APPLIED = 8'h0b;
   localparam logic [7:0] A_OUT_ROUTE_EN = 8'h0c;
   localparam logic [7:0] A_LED_CTRL = 8'h0d;
   localparam logic [7:0] A_STATUS = 8'h0e;
   localparam logic [7:0] A_IN_ROUTE_BASE = 8'h20;
   localparam logic [7:0] A_OUT_ROUTE_BASE = 8'h40;
   // Input source codes
   localparam logic [6:0] SRC_ZERO = 7'h00;
   localparam logic [6:0] SRC_IN_LAST = 7'h10;
   localparam logic [6:0] SRC_ENC_A = 7'h44;
   localparam logic [6:0] SRC_ENC_B = 7'h45;
   localparam logic [6:0] SRC_ENC_I = 7'h46;
   localparam logic [6:0] SRC_USB = 7'h47;
   localparam int SRC_INV_BIT = 7;
   // Output source codes (high byte of route entry)
   localparam logic [7:0] OSRC_ONE = 8'h00;
   localparam logic [7:0] OSRC_ZERO = 8'h01;
   localparam logic [7:0] OSRC_ENC_FIRST = 8'h02;
   localparam logic [7:0] OSRC_ENC_LAST = 8'h08;
   localparam logic [7:0] OSRC_PWM = 8'h10;
   localparam logic [7:0] OSRC_PWM_INV = 8'h11;
   localparam logic [15:0] OUT_ROUTE_OFF = 16'hffff;
   localparam int OUT_LEVEL_BASE = 16;
   localparam int BRAKE_BIT = 0;
   localparam int INTERLOCK_BIT = 3;
   localparam int GATE_INV_BIT = 7;
   // Sample period and LED flash
   localparam int CLK_HZ = 50_000_000;
   localparam int SAMPLE_US = 1000;
   localparam int SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
   localparam int LED_HALF_MS = 250;
   localparam int LED_TICKS = LED_HALF_MS * 1000 / SAMPLE_US;
   localparam logic [7:0] IN_ROUTE_RST = 8'h00;
   localparam logic [15:0] OUT_ROUTE_RST = 16'hffff;
   typedef struct packed {
      logic enc_a;
      logic enc_b;
      logic enc_i;
      logic usb_pwr;
   } dio_misc_s;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dio_bus_s;
endpackage : dio_pkg

// file: dio_route_mem.sv
// Route selector store; read data registered
module dio_route_mem #(
   parameter int DEPTH = 32,
   parameter int WIDTH = 8,
   parameter int AW = 5
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   input wire logic [WIDTH-1:0] rst_val,
   output logic [WIDTH-1:0] rdata,
   output logic [DEPTH*WIDTH-1:0] all_q
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (we) begin
         mem_q[waddr] <= wdata;
      end
   end
   // Contents are stored xor the reset value, so a cleared array reads as the reset value
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else begin
         rdata <= mem_q[raddr] ^ rst_val;
      end
   end
   for (genvar g = 0; g < DEPTH; g++) begin : g_all
      assign all_q[g*WIDTH +: WIDTH] = mem_q[g] ^ rst_val;
   end
endmodule : dio_route_mem

// file: dio_top.sv
// Summary of operation
// - Selector entry n picks the source for summary bit n-1
// - Code 0x00 is zero, 0x01..0x10 pick physical inputs 1..16
// - Codes 0x44..0x46 pick encoder A, B, index; 0x47 USB power
// - Bit 7 of a code inverts the source; 0x80 is one
// - Routing applies only while input routing enable is one
// - Interlock: bit 3 one permits motion, zero forces error and fault reaction
// - Interlock evaluated only when special-function bit 3 is set
// - Output n driven from control word bit 15+n
// - Low control bits are special; bit 0 drives the brake
// - Outputs are open drain: pull low or release
// - Polarity bit set makes a one drive a low level
// - Manual enable takes the output from the manual value, brake included
// - Applied output pattern is kept readable
// - Output routing active only while its enable is one
// - LED bits enable green normal flash and red error flash
// - Routed output is its source gated by an assigned control bit
// - Route entry: source in bits 15..8, gate index in bits 7..0
// - Output routing disables polarity and manual override
// - Input routing disables invert, force and special masking; special bit 3 still gates the interlock
// - Bit 7 of the gate index inverts the gate sense
// - Entry 0xFFFF switches routing off for that output
// - Inputs sampled each millisecond; shorter pulses ignored
//
// Chosen here: strobed register access and the address map.
module dio_top #(
   parameter int SAMPLE_CYCLES = dio_pkg::SAMPLE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [dio_pkg::NUM_IN-1:0] in_pins,
   input wire dio_pkg::dio_misc_s misc_in,
   input wire logic enc_pulse,
   input wire logic pwm_in,
   input wire logic drive_fault,
   output logic [dio_pkg::NUM_OUT-1:0] out_pins_o,
   output logic [dio_pkg::NUM_OUT-1:0] out_pins_oe,
   output logic brake_o,
   output logic brake_oe,
   output logic motion_permit,
   output logic fault_req,
   output logic led_green,
   output logic led_red
);
   localparam int NI = dio_pkg::NUM_IN;
   localparam int NO = dio_pkg::NUM_OUT;
   localparam int NB = dio_pkg::SUM_W;

   logic [15:0] in_spec_q, in_inv_q, in_fen_q, in_fval_q;
   logic in_route_en_q, out_route_en_q;
   logic [31:0] out_ctrl_q, out_pol_q, out_man_en_q, out_man_val_q, applied_q;
   logic [1:0] led_ctrl_q;
   logic [15:0] raw_q;
   logic [4:0] in_idx;
   logic [1:0] out_idx;
   logic [31:0] summary_q;
   logic [31:0] sample_cnt_q;
   logic tick;
   logic [NB*8-1:0] in_sel;
   logic [NO*16-1:0] out_sel;
   logic [6:0] enc_tog_q;
   logic [6:0] enc_carry;
   logic [7:0] led_cnt_q;
   logic led_phase_q;

   function automatic logic in_route_hit(input logic [7:0] a);
      in_route_hit = a >= dio_pkg::A_IN_ROUTE_BASE && a < dio_pkg::A_IN_ROUTE_BASE + 8'(NB);
   endfunction : in_route_hit

   function automatic logic out_route_hit(input logic [7:0] a);
      out_route_hit = a >= dio_pkg::A_OUT_ROUTE_BASE && a < dio_pkg::A_OUT_ROUTE_BASE + 8'(NO);
   endfunction : out_route_hit

   // Source decode for one input selector code
   function automatic logic in_src(input logic [7:0] code, input logic [15:0] raw,
                                   input dio_pkg::dio_misc_s m);
      logic base;
      base = 1'b0;
      if (code[6:0] >= 7'h01 && code[6:0] <= dio_pkg::SRC_IN_LAST) begin
         base = raw[4'(code[6:0] - 7'h01)];
      end else begin
         unique case (code[6:0])
            dio_pkg::SRC_ENC_A: base = m.enc_a;
            dio_pkg::SRC_ENC_B: base = m.enc_b;
            dio_pkg::SRC_ENC_I: base = m.enc_i;
            dio_pkg::SRC_USB: base = m.usb_pwr;
            default: base = 1'b0;
         endcase
      end
      in_src = base ^ code[dio_pkg::SRC_INV_BIT];
   endfunction : in_src

   // Offsets within each route window; only meaningful while the hit function agrees
   assign in_idx = 5'(addr - dio_pkg::A_IN_ROUTE_BASE);
   assign out_idx = 2'(addr - dio_pkg::A_OUT_ROUTE_BASE);

   // Selector stores; entries reset to code zero / routing off
   dio_route_mem #(.DEPTH(NB), .WIDTH(8), .AW(5)) u_in_route (
      .clk(clk),
      .rstn(rstn),
      .we(wr && in_route_hit(addr)),
      .waddr(in_idx),
      .wdata(wdata[7:0] ^ dio_pkg::IN_ROUTE_RST),
      .raddr(in_idx),
      .rst_val(dio_pkg::IN_ROUTE_RST),
      .rdata(),
      .all_q(in_sel)
   );
   dio_route_mem #(.DEPTH(NO), .WIDTH(16), .AW(2)) u_out_route (
      .clk(clk),
      .rstn(rstn),
      .we(wr && out_route_hit(addr)),
      .waddr(out_idx),
      .wdata(wdata[15:0] ^ dio_pkg::OUT_ROUTE_RST),
      .raddr(out_idx),
      .rst_val(dio_pkg::OUT_ROUTE_RST),
      .rdata(),
      .all_q(out_sel)
   );

   // Register writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         in_spec_q <= '0;
         in_inv_q <= '0;
         in_fen_q <= '0;
         in_fval_q <= '0;
         in_route_en_q <= 1'b0;
         out_ctrl_q <= '0;
         out_pol_q <= '0;
         out_man_en_q <= '0;
         out_man_val_q <= '0;
         out_route_en_q <= 1'b0;
         led_ctrl_q <= 2'b00;
      end else if (wr) begin
         unique case (addr)
            dio_pkg::A_IN_CFG_EN: in_spec_q <= wdata[15:0];
            dio_pkg::A_IN_INVERT: in_inv_q <= wdata[15:0];
            dio_pkg::A_IN_FORCE_EN: in_fen_q <= wdata[15:0];
            dio_pkg::A_IN_FORCE_VAL: in_fval_q <= wdata[15:0];
            dio_pkg::A_IN_ROUTE_EN: in_route_en_q <= wdata == 32'h0000_0001;
            dio_pkg::A_OUT_CTRL: out_ctrl_q <= wdata;
            dio_pkg::A_OUT_POL: out_pol_q <= wdata;
            dio_pkg::A_OUT_MAN_EN: out_man_en_q <= wdata;
            dio_pkg::A_OUT_MAN_VAL: out_man_val_q <= wdata;
            dio_pkg::A_OUT_ROUTE_EN: out_route_en_q <= wdata == 32'h0000_0001;
            dio_pkg::A_LED_CTRL: led_ctrl_q <= wdata[1:0];
            default: ;
         endcase
      end
   end

   // Millisecond sample tick; slower than any glitch worth seeing
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sample_cnt_q <= '0;
      end else if (sample_cnt_q == 32'(SAMPLE_CYCLES - 1)) begin
         sample_cnt_q <= '0;
      end else begin
         sample_cnt_q <= sample_cnt_q + 32'h0000_0001;
      end
   end
   assign tick = sample_cnt_q == 32'(SAMPLE_CYCLES - 1);

   // Inputs captured only on the tick, so short pulses between ticks vanish
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         raw_q <= '0;
      end else if (tick) begin
         raw_q <= in_pins;
      end
   end

   // Summary word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         summary_q <= '0;
      end else if (tick) begin
         if (in_route_en_q) begin
            for (int b = 0; b < NB; b++) begin
               summary_q[b] <= in_src(in_sel[b*8 +: 8], in_pins, misc_in);
            end
         end else begin
            // Fixed mapping: level bits ignore special-function enable
            for (int b = 0; b < NI; b++) begin
               summary_q[b] <= ((in_fen_q[b] ? in_fval_q[b] : in_pins[b]) ^ in_inv_q[b])
                  & in_spec_q[b];
               summary_q[dio_pkg::OUT_LEVEL_BASE + b] <=
                  (in_fen_q[b] ? in_fval_q[b] : in_pins[b]) ^ in_inv_q[b];
            end
         end
      end
   end

   // Interlock release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         motion_permit <= 1'b1;
         fault_req <= 1'b0;
      end else begin
         if (in_spec_q[dio_pkg::INTERLOCK_BIT] && !summary_q[dio_pkg::INTERLOCK_BIT]) begin
            motion_permit <= 1'b0;
            fault_req <= 1'b1;
         end else begin
            motion_permit <= 1'b1;
            fault_req <= 1'b0;
         end
      end
   end

   // Encoder pulse divider chain for output sources
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enc_tog_q <= '0;
      end else if (enc_pulse) begin
         enc_tog_q <= enc_tog_q ^ enc_carry;
      end
   end

   // Carry chain: a stage toggles only when every lower stage is one
   for (genvar k = 0; k < 7; k++) begin : g_enc_carry
      if (k == 0) begin : g_first
         assign enc_carry[k] = 1'b1;
      end else begin : g_next
         assign enc_carry[k] = &enc_tog_q[k-1:0];
      end
   end

   // Applied pattern computation
   logic [31:0] level;
   always_comb begin
      logic [15:0] ent;
      logic [7:0] src;
      logic sig, gate;
      ent = '0;
      src = '0;
      sig = 1'b0;
      gate = 1'b0;
      level = '0;
      for (int n = 0; n < NO; n++) begin
         ent = out_sel[n*16 +: 16];
         src = ent[15:8];
         gate = out_ctrl_q[ent[4:0]] ^ ent[dio_pkg::GATE_INV_BIT];
         unique case (1'b1)
            src == dio_pkg::OSRC_ONE: sig = 1'b1;
            src == dio_pkg::OSRC_PWM: sig = pwm_in;
            src == dio_pkg::OSRC_PWM_INV: sig = ~pwm_in;
            src >= dio_pkg::OSRC_ENC_FIRST && src <= dio_pkg::OSRC_ENC_LAST:
               sig = enc_tog_q[3'(src - dio_pkg::OSRC_ENC_FIRST)];
            default: sig = 1'b0;
         endcase
         if (out_route_en_q && ent != dio_pkg::OUT_ROUTE_OFF) begin
            level[dio_pkg::OUT_LEVEL_BASE + n] = sig & gate;
         end else begin
            level[dio_pkg::OUT_LEVEL_BASE + n] = out_ctrl_q[dio_pkg::OUT_LEVEL_BASE + n];
         end
      end
      level[dio_pkg::BRAKE_BIT] = out_ctrl_q[dio_pkg::BRAKE_BIT];
      if (!out_route_en_q) begin
         level = (out_man_en_q & out_man_val_q) | (~out_man_en_q & level);
         level = level ^ out_pol_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         applied_q <= '0;
      end else begin
         applied_q <= level;
      end
   end

   // Open drain: pull low for a low level, release for high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_pins_o <= '0;
         out_pins_oe <= '0;
         brake_o <= 1'b0;
         brake_oe <= 1'b0;
      end else begin
         out_pins_o <= '0;
         out_pins_oe <= ~level[dio_pkg::OUT_LEVEL_BASE +: NO];
         brake_o <= 1'b0;
         brake_oe <= ~level[dio_pkg::BRAKE_BIT];
      end
   end

   // LED flash on sample ticks
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         led_cnt_q <= '0;
         led_phase_q <= 1'b0;
      end else if (tick) begin
         if (led_cnt_q == 8'(dio_pkg::LED_TICKS - 1)) begin
            led_cnt_q <= '0;
            led_phase_q <= ~led_phase_q;
         end else begin
            led_cnt_q <= led_cnt_q + 8'h01;
         end
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         led_green <= 1'b0;
         led_red <= 1'b0;
      end else begin
         led_green <= led_ctrl_q[0] && !fault_req && !drive_fault && led_phase_q;
         led_red <= led_ctrl_q[1] && (fault_req || drive_fault) && led_phase_q;
      end
   end

   // Read path: data one cycle after the strobe, held until the next read; unmapped reads zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (rd) begin
         // Route entries come from the live store so readback keeps one cycle of latency
         if (in_route_hit(addr)) begin
            rdata <= {24'h00_0000, in_sel[in_idx*8 +: 8]};
         end else if (out_route_hit(addr)) begin
            rdata <= {16'h0000, out_sel[out_idx*16 +: 16]};
         end else begin
            unique case (addr)
               dio_pkg::A_IN_CFG_EN: rdata <= {16'h0000, in_spec_q};
               dio_pkg::A_IN_INVERT: rdata <= {16'h0000, in_inv_q};
               dio_pkg::A_IN_FORCE_EN: rdata <= {16'h0000, in_fen_q};
               dio_pkg::A_IN_FORCE_VAL: rdata <= {16'h0000, in_fval_q};
               dio_pkg::A_IN_RAW: rdata <= {16'h0000, raw_q};
               dio_pkg::A_IN_ROUTE_EN: rdata <= {31'h0000_0000, in_route_en_q};
               dio_pkg::A_IN_SUMMARY: rdata <= summary_q;
               dio_pkg::A_OUT_CTRL: rdata <= out_ctrl_q;
               dio_pkg::A_OUT_POL: rdata <= out_pol_q;
               dio_pkg::A_OUT_MAN_EN: rdata <= out_man_en_q;
               dio_pkg::A_OUT_MAN_VAL: rdata <= out_man_val_q;
               dio_pkg::A_OUT_APPLIED: rdata <= applied_q;
               dio_pkg::A_OUT_ROUTE_EN: rdata <= {31'h0000_0000, out_route_en_q};
               dio_pkg::A_LED_CTRL: rdata <= {30'h0000_0000, led_ctrl_q};
               dio_pkg::A_STATUS: rdata <= {30'h0000_0000, fault_req, motion_permit};
               default: rdata <= '0;
            endcase
         end
      end
   end
endmodule : dio_top

// file: dio_top_monitor.sv
module dio_top_monitor #(
   parameter int SAMPLE_CYCLES = 20
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   input wire logic [dio_pkg::NUM_OUT-1:0] out_pins_o,
   input wire logic [dio_pkg::NUM_OUT-1:0] out_pins_oe,
   input wire logic brake_o,
   input wire logic brake_oe,
   input wire logic motion_permit,
   input wire logic fault_req,
   input wire logic led_green,
   input wire logic led_red
);
   timeunit 1ns;
   timeprecision 1ps;
   // Release follows the write within two cycles, since it does not wait for a tick
   localparam int LIM = 2 * SAMPLE_CYCLES + 8;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence ctrl_wr;
      wr && addr == dio_pkg::A_OUT_CTRL;
   endsequence
   sequence ctrl_rd;
      rd && addr == dio_pkg::A_OUT_CTRL;
   endsequence
   od_data_low_a: assert property (out_pins_o == '0)
      else $error("open drain data not low");
   brake_data_low_a: assert property (!brake_o)
      else $error("brake data not low");
   fault_pair_a: assert property (fault_req == !motion_permit)
      else $error("fault request not inverse of permit");
   unmapped_zero_a: assert property (rd && addr inside {[8'h0f:8'h1f]} |=> rdata == '0)
      else $error("unmapped read not zero");
   led_off_a: assert property (wr && addr == dio_pkg::A_LED_CTRL && wdata[1:0] == 2'b00
      |-> ##2 (!led_green && !led_red) [*8])
      else $error("led lit while disabled");
   led_hold_a: assert property ($changed(led_green) |=> $stable(led_green) [*8])
      else $error("green led toggles too fast");
   reset_vals_a: assert property ($rose(rstn) |-> out_pins_oe == '0 && !brake_oe
      && motion_permit && !led_green && !led_red)
      else $error("bad value after reset");
   permit_release_a: assert property (wr && addr == dio_pkg::A_IN_CFG_EN && !wdata[3]
      |-> ##[1:LIM] motion_permit)
      else $error("permit not restored");
   ctrl_back_a: assert property (ctrl_wr ##2 ctrl_rd |=> rdata == $past(wdata, 3))
      else $error("control word readback wrong");
endmodule : dio_top_monitor

bind dio_top dio_top_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_mon (.clk, .rstn, .addr,
   .wdata, .wr, .rd, .rdata, .out_pins_o, .out_pins_oe, .brake_o, .brake_oe,
   .motion_permit, .fault_req, .led_green, .led_red);

// file: dio_field_model.sv
module dio_field_model (
   input wire logic [15:0] pins_set,
   input wire logic [3:0] misc_set,
   input wire logic [3:0] out_pins_o,
   input wire logic [3:0] out_pins_oe,
   input wire logic brake_o,
   input wire logic brake_oe,
   output logic [15:0] in_pins,
   output dio_pkg::dio_misc_s misc_in,
   output logic [3:0] out_lvl,
   output logic brake_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   assign in_pins = pins_set;
   assign misc_in = misc_set;
   // External pull-ups give the high level; only an enabled driver pulls low
   assign out_lvl = (out_pins_oe & out_pins_o) | ~out_pins_oe;
   assign brake_lvl = brake_oe ? brake_o : 1'b1;
endmodule : dio_field_model

// file: dio_top_tb.sv
module dio_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 20;
   localparam logic [7:0] CODES [10] = '{8'h00, 8'h80, 8'h44, 8'h45, 8'h46, 8'h47,
      8'hc4, 8'hc5, 8'hc6, 8'hc7};
   localparam logic [31:0] OC [3] = '{32'h0005_0001, 32'h0005_0001, 32'h0005_0001};
   localparam logic [31:0] OP [3] = '{32'h0, 32'h000f_0001, 32'h0};
   localparam logic [31:0] OM [3] = '{32'h0, 32'h0, 32'h0003_0001};
   localparam logic [31:0] OV [3] = '{32'h0, 32'h0, 32'h0002_0000};
   localparam logic [31:0] OL [3] = '{32'h0005_0001, 32'h000a_0000, 32'h0006_0000};
   localparam logic [15:0] RE [4] = '{16'h0005, 16'h0085, 16'h0105, 16'h0085};
   localparam logic [31:0] RC [4] = '{32'h20, 32'h0, 32'h20, 32'h20};
   localparam logic [3:0] RL [4] = '{4'hf, 4'hf, 4'h0, 4'h0};
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic drive_fault = 1'b0;
   logic [15:0] pins_set = 16'h0000;
   logic [3:0] misc_set = 4'h0;
   logic [31:0] rdata, d;
   logic [15:0] in_pins;
   dio_pkg::dio_misc_s misc_in;
   logic [3:0] out_pins_o, out_pins_oe, lvl;
   logic brake_o, brake_oe, blvl, motion_permit, fault_req, led_green, led_red;
   logic [7:0] route [32];
   int err_total = 0;
   int tests_run = 0;
   int g, r;

   always #10 clk = ~clk;

   dio_top #(.SAMPLE_CYCLES(SC)) u_dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
      .in_pins, .misc_in, .enc_pulse(1'b0), .pwm_in(1'b0), .drive_fault, .out_pins_o,
      .out_pins_oe, .brake_o, .brake_oe, .motion_permit, .fault_req, .led_green, .led_red);
   dio_field_model u_field (.pins_set, .misc_set, .out_pins_o, .out_pins_oe, .brake_o,
      .brake_oe, .in_pins, .misc_in, .out_lvl(lvl), .brake_lvl(blvl));

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic settle();
      repeat (3 * SC) @(posedge clk);
      #1;
   endtask : settle
   function automatic logic src(input logic [7:0] c);
      logic v;
      case (c[6:0])
         7'h44: v = misc_set[3];
         7'h45: v = misc_set[2];
         7'h46: v = misc_set[1];
         7'h47: v = misc_set[0];
         default: v = (c[6:0] >= 7'h01 && c[6:0] <= 7'h10) ? pins_set[c[6:0] - 7'h01] : 1'b0;
      endcase
      return v ^ c[7];
   endfunction : src
   task automatic sum_chk();
      logic [31:0] e;
      for (int b = 0; b < 32; b++) e[b] = src(route[b]);
      rd_reg(dio_pkg::A_IN_SUMMARY, d);
      chk("summary", d, e);
   endtask : sum_chk
   task automatic watch(input int n, output int gc, output int rc);
      logic pg, pr;
      gc = 0;
      rc = 0;
      pg = led_green;
      pr = led_red;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (led_green !== pg) gc++;
         if (led_red !== pr) rc++;
         pg = led_green;
         pr = led_red;
      end
   endtask : watch
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      // Bound of 50000 cycles; the whole sequence needs about 25000
      #1_000_000;
      err_total++;
      finish_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(dio_pkg::A_IN_ROUTE_BASE, d);
      chk("in_route_rst", d, 32'h0000_0000);
      rd_reg(dio_pkg::A_OUT_ROUTE_BASE + 8'h01, d);
      chk("out_route_rst", d, 32'h0000_ffff);
      rd_reg(8'h1f, d);
      chk("unmapped", d, 32'h0000_0000);
      $display("test reset done");
      pins_set <= 16'ha5c3;
      settle();
      rd_reg(dio_pkg::A_IN_SUMMARY, d);
      chk("fixed_summary", d, 32'ha5c3_0000);
      wr_reg(dio_pkg::A_IN_CFG_EN, 32'h0000_00ff);
      settle();
      rd_reg(dio_pkg::A_IN_SUMMARY, d);
      chk("special_summary", d, 32'ha5c3_00c3);
      chk("permit_low", motion_permit, 1'b0);
      chk("fault_high", fault_req, 1'b1);
      wr_reg(dio_pkg::A_IN_CFG_EN, 32'h0000_0000);
      settle();
      chk("permit_back", motion_permit, 1'b1);
      $display("test fixed inputs done");
      // Invert and force must be ignored once routing is on
      wr_reg(dio_pkg::A_IN_INVERT, 32'h0000_ffff);
      wr_reg(dio_pkg::A_IN_FORCE_EN, 32'h0000_ffff);
      wr_reg(dio_pkg::A_IN_ROUTE_EN, 32'h0000_0001);
      for (int b = 0; b < 16; b++) begin
         route[b] = 8'(b + 1);
         route[b + 16] = 8'h80 | 8'(b + 1);
         wr_reg(dio_pkg::A_IN_ROUTE_BASE + 8'(b), {24'h0, route[b]});
         wr_reg(dio_pkg::A_IN_ROUTE_BASE + 8'(b + 16), {24'h0, route[b + 16]});
      end
      settle();
      sum_chk();
      misc_set <= 4'b1010;
      pins_set <= 16'h3c96;
      for (int i = 0; i < 10; i++) begin
         route[i] = CODES[i];
         wr_reg(dio_pkg::A_IN_ROUTE_BASE + 8'(i), {24'h0, route[i]});
      end
      settle();
      sum_chk();
      $display("test input routing done");
      for (int i = 0; i < 3; i++) begin
         wr_reg(dio_pkg::A_OUT_POL, OP[i]);
         wr_reg(dio_pkg::A_OUT_MAN_EN, OM[i]);
         wr_reg(dio_pkg::A_OUT_MAN_VAL, OV[i]);
         wr_reg(dio_pkg::A_OUT_CTRL, OC[i]);
         rd_reg(dio_pkg::A_OUT_CTRL, d);
         chk("ctrl_back", d, OC[i]);
         settle();
         chk("out_levels", {lvl, blvl}, {OL[i][19:16], OL[i][0]});
         rd_reg(dio_pkg::A_OUT_APPLIED, d);
         chk("applied", d & 32'h000f_0001, OL[i]);
      end
      $display("test outputs done");
      wr_reg(dio_pkg::A_OUT_POL, 32'h000f_0001);
      wr_reg(dio_pkg::A_OUT_MAN_EN, 32'h000f_0001);
      wr_reg(dio_pkg::A_OUT_MAN_VAL, 32'h0000_0000);
      wr_reg(dio_pkg::A_OUT_ROUTE_EN, 32'h0000_0001);
      for (int i = 0; i < 4; i++) begin
         for (int a = 0; a < 5; a++) wr_reg(dio_pkg::A_OUT_ROUTE_BASE + 8'(a), {16'h0, RE[i]});
         wr_reg(dio_pkg::A_OUT_CTRL, RC[i]);
         settle();
         chk("routed_out", lvl, RL[i]);
      end
      $display("test output routing done");
      wr_reg(dio_pkg::A_LED_CTRL, 32'h0000_0003);
      watch(11000, g, r);
      chk("green_flash", g >= 2, 1'b1);
      chk("red_quiet", r, 32'h0);
      drive_fault <= 1'b1;
      watch(11000, g, r);
      chk("red_flash", r >= 2, 1'b1);
      wr_reg(dio_pkg::A_LED_CTRL, 32'h0000_0000);
      repeat (4) @(posedge clk);
      #1;
      chk("leds_off", {led_green, led_red}, 2'b00);
      $display("test leds done");
      finish_test();
   end
endmodule : dio_top_tb
